// file: common/sdcl_map.svh
`ifndef SDCL_MAP_SVH
`define SDCL_MAP_SVH

// ==========================================================
// register offsets (byte addresses, one aligned word each)
`define SDCL_REG_STATUS 8'h00
`define SDCL_REG_SHIFT 8'h04
`define SDCL_REG_CTRL 8'h08

// ==========================================================
// status register fields
`define SDCL_ST_FB_LSB 0
`define SDCL_ST_CODE_LSB 9
`define SDCL_ST_TEST_LSB 12
`define SDCL_ST_PAR_BIT 16
`define SDCL_ST_PDUP_BIT 17
`define SDCL_ST_PDDN_BIT 18
`define SDCL_ST_STATE_LSB 19

// ==========================================================
// control register fields and reset value
`define SDCL_CTRL_SOFT_RST_BIT 0
`define SDCL_CTRL_TEST_LOW_BIT 1
`define SDCL_CTRL_RST 2'h0

// ==========================================================
// configuration reset values
`define SDCL_FB_RST 9'h190
`define SDCL_CODE_RST 3'h0
`define SDCL_TEST_RST 2'h0

// ==========================================================
// fixed ratios and frame length
`define SDCL_REF_DIV 5'h10
`define SDCL_FRAME_BITS 14

`endif

// file: common/sdcl_pkg.sv
package sdcl_pkg;

   // ==========================================================
   // active configuration
   typedef struct packed {
      logic [1:0] test_sel;
      logic [2:0] out_div_code;
      logic [8:0] feedback_div_bits;
   } sdcl_cfg_s;

   // ==========================================================
   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sdcl_apb_req_s;

   // ==========================================================
   // which path owns the active configuration
   typedef enum logic [1:0] {
      LOAD_PARALLEL,
      LOAD_HELD,
      LOAD_SERIAL_PASS
   } sdcl_load_e;

   // half of the output divide ratio; all ratios even so duty stays 50%
   function automatic logic [4:0] sdcl_half_ratio(input logic [2:0] code);
      logic [4:0] half;
      case (code)
         3'h0: half = 5'h01;
         3'h1: half = 5'h02;
         3'h2: half = 5'h03;
         3'h3: half = 5'h04;
         3'h4: half = 5'h06;
         3'h5: half = 5'h08;
         3'h6: half = 5'h0C;
         default: half = 5'h10;
      endcase
      return half;
   endfunction

endpackage

// file: hdl/sdcl_config.sv
// Contract
// - reference is the selected oscillator or test clock divided by sixteen
// - core runs at reference times the feedback divider value
// - each output equals core frequency over the selected output ratio
// - output divider keeps fifty percent duty at every ratio
// - parallel load low: dividers follow parallel feedback and output bits
// - parallel load rising: bits held until it falls or serial event
// - strapped parallel bits set dividers at power-up with no host
// - test output low in parallel mode
// - serial mode shifts data pin in on each rising shift clock
// - serial load rising copies shift register into dividers
// - serial load falling latches and holds the divider values
// - serial load high passes data to dividers on every shift clock
// - serial path loads feedback, output code and test select bits
// - test select: low, shift input, feedback output, output clock copy
// - master reset clears dividers, true outputs low, keeps configuration
// - reference select high picks oscillator, low picks test clock
`timescale 1ns/1ps
`include "sdcl_map.svh"

module sdcl_config
   import sdcl_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // reference clocks
   input wire logic i_xtal_clk,
   input wire logic i_test_clk,
   input wire logic i_ref_source_select,
   input wire logic i_pll_bypass_select,
   // parallel port
   input wire logic i_parallel_load_n,
   input wire logic [8:0] i_feedback_div_bits,
   input wire logic [2:0] i_out_div_code,
   // serial port
   input wire logic i_shift_clk,
   input wire logic i_shift_data,
   input wire logic i_shift_load,
   // reset pin
   input wire logic i_master_reset,
   // apb slave
   input wire sdcl_apb_req_s i_apb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // clock outputs
   output logic o_clk_out_a,
   output logic o_clk_out_a_n,
   output logic o_clk_out_b,
   output logic o_clk_out_b_n,
   output logic o_test
);

   // ==========================================================
   // pin synchronisers
   localparam int PINS = 21;
   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] pin_s1;
   logic [PINS-1:0] pin_s2;
   logic [PINS-1:0] pin_prev;

   assign pin_raw = {i_feedback_div_bits, i_out_div_code, i_xtal_clk, i_test_clk,
                     i_ref_source_select, i_pll_bypass_select, i_parallel_load_n,
                     i_shift_clk, i_shift_data, i_shift_load, i_master_reset};

   // no reset: pins flow through reset, so no false edge or zero strap follows it
   always_ff @(posedge i_sys_clk) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
   end

   logic [8:0] par_fb;
   logic [2:0] par_code;
   logic xtal_rise;
   logic test_rise;
   logic ref_sel;
   logic pll_on;
   logic pload_n;
   logic pload_rise;
   logic sclk_rise;
   logic sdata;
   logic sload;
   logic sload_rise;
   logic sload_fall;
   logic mr_pin;

   assign par_fb = pin_s2[20:12];
   assign par_code = pin_s2[11:9];
   assign xtal_rise = pin_s2[8] & ~pin_prev[8];
   assign test_rise = pin_s2[7] & ~pin_prev[7];
   assign ref_sel = pin_s2[6];
   assign pll_on = pin_s2[5];
   assign pload_n = pin_s2[4];
   assign pload_rise = pin_s2[4] & ~pin_prev[4];
   assign sclk_rise = pin_s2[3] & ~pin_prev[3];
   assign sdata = pin_s2[2];
   assign sload = pin_s2[1];
   assign sload_rise = pin_s2[1] & ~pin_prev[1];
   assign sload_fall = ~pin_s2[1] & pin_prev[1];
   assign mr_pin = pin_s2[0];

   // ==========================================================
   // control register and divider reset
   logic [1:0] ctrl;
   logic div_clear;

   assign div_clear = mr_pin | ctrl[`SDCL_CTRL_SOFT_RST_BIT];

   // ==========================================================
   // reference selection and fixed divide
   logic ref_edge;
   logic [4:0] ref_cnt;
   logic ref_tick;

   assign ref_edge = ref_sel ? xtal_rise : test_rise;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || div_clear) begin
         ref_cnt <= 5'h00;
         ref_tick <= 1'b0;
      end else begin
         ref_tick <= 1'b0;
         if (ref_edge) begin
            if (ref_cnt >= `SDCL_REF_DIV - 5'h01) begin
               ref_cnt <= 5'h00;
               ref_tick <= 1'b1;
            end else begin
               ref_cnt <= ref_cnt + 5'h01;
            end
         end
      end
   end

   // ==========================================================
   // serial shift register, msb first
   logic [`SDCL_FRAME_BITS-1:0] shreg;
   logic [`SDCL_FRAME_BITS-1:0] next_shreg;

   assign next_shreg = {shreg[`SDCL_FRAME_BITS-2:0], sdata};

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         shreg <= '0;
      end else if (pload_n && sclk_rise) begin
         shreg <= next_shreg;
      end
   end

   // ==========================================================
   // active configuration and owning path
   sdcl_cfg_s cfg;
   sdcl_load_e load_state;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cfg.feedback_div_bits <= `SDCL_FB_RST;
         cfg.out_div_code <= `SDCL_CODE_RST;
         cfg.test_sel <= `SDCL_TEST_RST;
      end else if (!pload_n) begin
         // straps reach the dividers with no host write
         cfg.feedback_div_bits <= par_fb;
         cfg.out_div_code <= par_code;
      end else if (pload_rise) begin
         // pin_prev is one edge behind pin_s2, so the last followed bits stay
         cfg <= cfg;
      end else if (sload && sclk_rise) begin
         cfg <= sdcl_cfg_s'(next_shreg);
      end else if (sload_rise) begin
         cfg <= sdcl_cfg_s'(shreg);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         load_state <= LOAD_PARALLEL;
      end else begin
         case (load_state)
            LOAD_PARALLEL: begin
               if (pload_n) begin
                  load_state <= LOAD_HELD;
               end
            end
            LOAD_HELD: begin
               if (!pload_n) begin
                  load_state <= LOAD_PARALLEL;
               end else if (sload_rise) begin
                  load_state <= LOAD_SERIAL_PASS;
               end
            end
            LOAD_SERIAL_PASS: begin
               if (!pload_n) begin
                  load_state <= LOAD_PARALLEL;
               end else if (sload_fall) begin
                  load_state <= LOAD_HELD;
               end
            end
            default: begin
               load_state <= LOAD_PARALLEL;
            end
         endcase
      end
   end

   // ==========================================================
   // core tick: system clock stands in for the oscillator core
   logic core_tick;

   assign core_tick = pll_on ? 1'b1 : ref_edge;

   // ==========================================================
   // feedback divider
   logic [8:0] fb_cnt;
   logic fb_tick;
   logic fb_out;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || div_clear) begin
         fb_cnt <= 9'h000;
         fb_tick <= 1'b0;
         fb_out <= 1'b0;
      end else begin
         fb_tick <= 1'b0;
         // a zero value would wrap only at 511 (0 - 1), dividing by 512; it simply holds the divider
         if (core_tick && cfg.feedback_div_bits != 9'h000) begin
            if (fb_cnt >= cfg.feedback_div_bits - 9'h001) begin
               fb_cnt <= 9'h000;
               fb_tick <= 1'b1;
               fb_out <= ~fb_out;
            end else begin
               fb_cnt <= fb_cnt + 9'h001;
            end
         end
      end
   end

   // ==========================================================
   // phase and frequency detector state
   logic pd_up;
   logic pd_dn;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || div_clear) begin
         pd_up <= 1'b0;
         pd_dn <= 1'b0;
      end else if (ref_tick && fb_tick) begin
         pd_up <= 1'b0;
         pd_dn <= 1'b0;
      end else if (ref_tick) begin
         pd_up <= ~pd_dn;
         pd_dn <= 1'b0;
      end else if (fb_tick) begin
         pd_dn <= ~pd_up;
         pd_up <= 1'b0;
      end
   end

   // ==========================================================
   // output divider and output stage
   logic div_clk;

   sdcl_out_div u_out_div (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_tick(core_tick),
      .i_clear(div_clear),
      .i_half(sdcl_half_ratio(cfg.out_div_code)),
      .o_clk(div_clk)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || div_clear) begin
         o_clk_out_a <= 1'b0;
         o_clk_out_a_n <= 1'b1;
         o_clk_out_b <= 1'b0;
         o_clk_out_b_n <= 1'b1;
      end else begin
         o_clk_out_a <= div_clk;
         o_clk_out_a_n <= ~div_clk;
         o_clk_out_b <= div_clk;
         o_clk_out_b_n <= ~div_clk;
      end
   end

   // ==========================================================
   // test output
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !pload_n || ctrl[`SDCL_CTRL_TEST_LOW_BIT]) begin
         o_test <= 1'b0;
      end else begin
         case (cfg.test_sel)
            2'h0: o_test <= 1'b0;
            2'h1: o_test <= sdata;
            2'h2: o_test <= fb_out;
            default: o_test <= div_clk;
         endcase
      end
   end

   // ==========================================================
   // apb slave: one wait state, then pready
   logic apb_access;
   logic apb_done;
   logic [31:0] status_word;

   assign apb_access = i_apb.psel & i_apb.penable;
   assign apb_done = apb_access & o_pready;

   always_comb begin
      status_word = 32'h00000000;
      status_word[`SDCL_ST_FB_LSB +: 9] = cfg.feedback_div_bits;
      status_word[`SDCL_ST_CODE_LSB +: 3] = cfg.out_div_code;
      status_word[`SDCL_ST_TEST_LSB +: 2] = cfg.test_sel;
      status_word[`SDCL_ST_PAR_BIT] = ~pload_n;
      status_word[`SDCL_ST_PDUP_BIT] = pd_up;
      status_word[`SDCL_ST_PDDN_BIT] = pd_dn;
      status_word[`SDCL_ST_STATE_LSB +: 2] = load_state;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else if (apb_access && !o_pready) begin
         o_pready <= 1'b1;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
         case (i_apb.paddr)
            `SDCL_REG_STATUS: o_prdata <= i_apb.pwrite ? 32'h00000000 : status_word;
            `SDCL_REG_SHIFT: o_prdata <= i_apb.pwrite ? 32'h00000000 : 32'(shreg);
            `SDCL_REG_CTRL: o_prdata <= i_apb.pwrite ? 32'h00000000 : 32'(ctrl);
            default: o_pslverr <= 1'b1;
         endcase
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end
   end

   // writes land only on the completing edge; status and shift are read-only
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ctrl <= `SDCL_CTRL_RST;
      end else if (apb_done && i_apb.pwrite && i_apb.paddr == `SDCL_REG_CTRL) begin
         ctrl <= i_apb.pwdata[1:0];
      end
   end

endmodule // sdcl_config

// file: hdl/sdcl_out_div.sv
`timescale 1ns/1ps

module sdcl_out_div
   import sdcl_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // control
   input wire logic i_tick,
   input wire logic i_clear,
   input wire logic [4:0] i_half,
   // divided clock
   output logic o_clk
);

   logic [4:0] cnt;

   // ==========================================================
   // equal high and low halves give the 50% duty
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || i_clear) begin
         cnt <= 5'h00;
         o_clk <= 1'b0;
      end else if (i_tick) begin
         // a ratio change mid-count wraps at once instead of running long
         if (cnt >= i_half - 5'h01) begin
            cnt <= 5'h00;
            o_clk <= ~o_clk;
         end else begin
            cnt <= cnt + 5'h01;
         end
      end
   end

endmodule // sdcl_out_div

// file: tb/sdcl_config_asserts.sv
`timescale 1ns/1ps

// ==========
// port checker for the divider configuration block
module sdcl_config_asserts
   import sdcl_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // pins
   input wire logic i_parallel_load_n,
   input wire logic i_master_reset,
   input wire sdcl_apb_req_s i_apb,
   // outputs
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_clk_out_a,
   input wire logic o_clk_out_a_n,
   input wire logic o_clk_out_b,
   input wire logic o_clk_out_b_n,
   input wire logic o_test
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // six clocks cover the pin synchronisers plus the output register
   AST_TEST_LOW_PAR: assert property ((!i_parallel_load_n) [*6] |-> !o_test)
      else $error("test output high in parallel mode");
   AST_MR_FORCE: assert property (i_master_reset [*6] |->
      !o_clk_out_a && !o_clk_out_b && o_clk_out_a_n && o_clk_out_b_n)
      else $error("outputs not forced by master reset");
   AST_PAIR_A: assert property (o_clk_out_a_n == !o_clk_out_a)
      else $error("output a pair not complementary");
   AST_PAIR_B: assert property (o_clk_out_b_n == !o_clk_out_b)
      else $error("output b pair not complementary");
   AST_APB_WAIT: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready)
      else $error("apb answer late");
   AST_APB_ONE: assert property (o_pready |=> !o_pready)
      else $error("apb ready held too long");
   AST_APB_CAUSE: assert property (o_pready |-> $past(i_apb.psel && i_apb.penable))
      else $error("apb ready without access");
   AST_APB_ERR: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("apb error with data");
endmodule // sdcl_config_asserts

bind sdcl_config sdcl_config_asserts i_chk (.i_sys_clk, .i_rst, .i_parallel_load_n,
   .i_master_reset, .i_apb, .o_prdata, .o_pready, .o_pslverr, .o_clk_out_a,
   .o_clk_out_a_n, .o_clk_out_b, .o_clk_out_b_n, .o_test);

// file: tb/sdcl_host_model.sv
`timescale 1ns/1ps

// ==========
// host pins: straps, serial frames, master reset
module sdcl_host_model (
   // clock
   input wire logic i_sys_clk,
   // pins
   output logic o_xtal_clk,
   output logic o_test_clk,
   output logic o_parallel_load_n,
   output logic [8:0] o_feedback_div_bits,
   output logic [2:0] o_out_div_code,
   output logic o_shift_clk,
   output logic o_shift_data,
   output logic o_shift_load,
   output logic o_master_reset
);
   // straps valid from power-up; references run free of the system clock
   initial begin
      o_xtal_clk = 1'b0;
      o_test_clk = 1'b0;
      o_parallel_load_n = 1'b0;
      o_feedback_div_bits = 9'h12C;
      o_out_div_code = 3'h3;
      o_shift_clk = 1'b0;
      o_shift_data = 1'b0;
      o_shift_load = 1'b0;
      o_master_reset = 1'b0;
   end
   always #31 o_xtal_clk = !o_xtal_clk;
   always #47 o_test_clk = !o_test_clk;

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   // every pin move is held 8 clocks, past the input synchronisers
   task automatic set_par(input logic [8:0] fb, input logic [2:0] cd, input logic ld_n);
      tick(1);
      o_feedback_div_bits <= fb;
      o_out_div_code <= cd;
      o_parallel_load_n <= ld_n;
      tick(8);
   endtask

   task automatic set_load(input logic v);
      tick(1);
      o_shift_load <= v;
      tick(8);
   endtask

   task automatic set_mr(input logic v);
      tick(1);
      o_master_reset <= v;
      tick(8);
   endtask

   // msb first; data drops to the pulldown level once its hold has run out
   task automatic send_frame(input logic [13:0] f, input int slow);
      for (int i = 13; i >= 0; i--) begin
         o_shift_data <= f[i];
         tick(4);
         o_shift_clk <= 1'b1;
         tick(4 + slow);
         o_shift_clk <= 1'b0;
         o_shift_data <= 1'b0;
         tick(4);
      end
   endtask
endmodule // sdcl_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "sdcl_map.svh"

// ==========
// bench: apb driver notes answers, monitor compares
module testbench
   import sdcl_pkg::*;
;
   localparam logic [31:0] st_mask = 32'hFFF9FFFF;
   localparam logic [31:0] all_ones = 32'hFFFFFFFF;
   logic i_sys_clk;
   logic i_rst;
   logic ref_sel;
   logic bypass;
   sdcl_apb_req_s apb;
   logic [31:0] prdata;
   logic pready, pslverr, ca, can, cb, cbn, tst;
   logic xclk, tclk, pload_n, sclk, sdata, sload, mr;
   logic [8:0] fb_pins;
   logic [2:0] code_pins;
   logic [32:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] lfsr = 32'h000129DD;
   logic [5:0] ratio [8] = '{6'h02, 6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20};
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;

   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = !i_sys_clk;
   end

   sdcl_config i_dut (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_xtal_clk(xclk), .i_test_clk(tclk),
      .i_ref_source_select(ref_sel), .i_pll_bypass_select(bypass),
      .i_parallel_load_n(pload_n), .i_feedback_div_bits(fb_pins), .i_out_div_code(code_pins),
      .i_shift_clk(sclk), .i_shift_data(sdata), .i_shift_load(sload), .i_master_reset(mr),
      .i_apb(apb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_clk_out_a(ca), .o_clk_out_a_n(can), .o_clk_out_b(cb), .o_clk_out_b_n(cbn),
      .o_test(tst)
   );

   sdcl_host_model i_host (
      .i_sys_clk(i_sys_clk), .o_xtal_clk(xclk), .o_test_clk(tclk), .o_parallel_load_n(pload_n),
      .o_feedback_div_bits(fb_pins), .o_out_div_code(code_pins), .o_shift_clk(sclk),
      .o_shift_data(sdata), .o_shift_load(sload), .o_master_reset(mr)
   );

   // ==========
   // helpers
   function automatic logic [8:0] rnd_fb();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return 9'(250 + lfsr[15:0] % 251);
   endfunction

   function automatic logic [31:0] st(input logic [13:0] c, input logic par, input logic [1:0] ld);
      return {11'h0, ld, 2'b00, par, 2'h0, c};
   endfunction

   task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic apb_do(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic err, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({err, e & m});
      msk_q.push_back(m);
      @(posedge i_sys_clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_sys_clk);
      apb.penable <= 1'b1;
      do @(posedge i_sys_clk); while (pready !== 1'b1);
      apb <= '0;
   endtask

   // one high and one low phase of output a, counted in system clocks
   task automatic span(output int hi, output int lo);
      hi = 0;
      lo = 0;
      repeat (40) @(posedge i_sys_clk);
      while (ca !== 1'b0) @(posedge i_sys_clk);
      while (ca !== 1'b1) @(posedge i_sys_clk);
      while (ca === 1'b1) begin
         hi++;
         @(posedge i_sys_clk);
      end
      while (ca === 1'b0) begin
         lo++;
         @(posedge i_sys_clk);
      end
   endtask

   // core ticks every system clock, so both halves are fixed by the ratio
   task automatic measure(input logic [2:0] c);
      int hi;
      int lo;
      span(hi, lo);
      check("high time", 33'(ratio[c] / 2), 33'(hi));
      check("period", 33'(ratio[c]), 33'(hi + lo));
      check("output pairs", 33'({ca, ca, ca}), 33'({cb, ~can, ~cbn}));
   endtask

   // bypass: core ticks on sampled reference edges, one clock of jitter each
   task automatic ref_period(input logic s, input int lo_lim, input int hi_lim);
      int hi;
      int lo;
      ref_sel <= s;
      i_host.set_par(9'h12C, 3'h0, 1'b0);
      span(hi, lo);
      check("bypass period", 33'h1, 33'(hi + lo >= lo_lim && hi + lo <= hi_lim));
   endtask

   // ==========
   // answer monitor and timeout
   always @(posedge i_sys_clk) begin
      if (pready === 1'b1 && exp_q.size() > 0) begin
         check("apb answer", exp_q.pop_front(), {pslverr, prdata & msk_q.pop_front()});
      end
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // ==========
   // main sequence
   initial begin
      logic [13:0] cur;
      logic [13:0] f;
      logic [13:0] g;
      logic [8:0] fb;
      logic [2:0] cd;
      i_rst = 1'b1;
      ref_sel = 1'b1;
      bypass = 1'b1;
      apb = '0;
      repeat (16) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(14'h072C, 1'b1, 2'h0), st_mask);
      apb_do(1'b0, `SDCL_REG_CTRL, 32'h0, 1'b0, 32'h0, all_ones);
      apb_do(1'b0, 8'h0C, 32'h0, 1'b1, 32'h0, all_ones);
      apb_do(1'b1, `SDCL_REG_STATUS, all_ones, 1'b0, 32'h0, 32'h0);
      // transparent, then held while the pins move on
      fb = rnd_fb();
      cd = lfsr[18:16];
      cur = {2'h0, cd, fb};
      i_host.set_par(fb, cd, 1'b0);
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(cur, 1'b1, 2'h0), st_mask);
      i_host.set_par(fb, cd, 1'b1);
      i_host.set_par(~fb, ~cd, 1'b1);
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(cur, 1'b0, 2'h1), st_mask);
      // every test select code, shift clock slower each frame
      for (int k = 0; k < 4; k++) begin
         fb = rnd_fb();
         f = {k[1:0], lfsr[18:16], fb};
         i_host.send_frame(f, k);
         apb_do(1'b0, `SDCL_REG_SHIFT, 32'h0, 1'b0, {18'h0, f}, all_ones);
         apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(cur, 1'b0, 2'h1), st_mask);
         i_host.set_load(1'b1);
         i_host.set_load(1'b0);
         cur = f;
         apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(f, 1'b0, 2'h1), st_mask);
         // code 01 shows the idle data pin, code 11 the divided clock
         if (k != 2) check("test pin", {32'h0, (k == 3) ? ca : 1'b0}, {32'h0, tst});
      end
      // load held high: each shift clock goes straight through
      fb = rnd_fb();
      f = {2'h3, lfsr[18:16], fb};
      i_host.set_load(1'b1);
      i_host.send_frame(f, 0);
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(f, 1'b0, 2'h2), st_mask);
      i_host.set_load(1'b0);
      // shift clock ignored while parallel load is low; serial then beats held pins
      fb = rnd_fb();
      g = {2'h1, lfsr[18:16], rnd_fb()};
      i_host.set_par(fb, 3'h5, 1'b0);
      i_host.send_frame(g, 0);
      apb_do(1'b0, `SDCL_REG_SHIFT, 32'h0, 1'b0, {18'h0, f}, all_ones);
      // test select is serial-only, so it keeps the value of the last frame
      cur = {f[13:12], 3'h5, fb};
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(cur, 1'b1, 2'h0), st_mask);
      i_host.set_par(fb, 3'h5, 1'b1);
      i_host.send_frame(g, 1);
      i_host.set_load(1'b1);
      i_host.set_load(1'b0);
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(g, 1'b0, 2'h1), st_mask);
      // divider reset keeps the loaded configuration
      i_host.set_mr(1'b1);
      apb_do(1'b0, `SDCL_REG_STATUS, 32'h0, 1'b0, st(g, 1'b0, 2'h1), st_mask);
      i_host.set_mr(1'b0);
      apb_do(1'b1, `SDCL_REG_CTRL, 32'h3, 1'b0, 32'h0, 32'h0);
      apb_do(1'b0, `SDCL_REG_CTRL, 32'h0, 1'b0, 32'h3, all_ones);
      apb_do(1'b1, `SDCL_REG_CTRL, 32'h0, 1'b0, 32'h0, 32'h0);
      // every output ratio through the parallel pins
      for (int c = 0; c < 8; c++) begin
         ref_sel <= lfsr[c];
         i_host.set_par(9'h12C, 3'(c), 1'b0);
         measure(3'(c));
      end
      // bypass at ratio 2: period is two reference periods, crystal then test clock
      bypass <= 1'b0;
      ref_period(1'b1, 24, 26);
      ref_period(1'b0, 36, 39);
      tally_and_finish();
   end
endmodule // testbench
